// ==== apm_event_status_enable.sv ====
// Power management event status and enable logic: sticky event flags,
// control interrupt and wake generation, power-on output control.
// Assumes byte accesses from system I/O decode on clock_i; the button
// arrives from a pin, all other event inputs are synchronous to clock_i.
//
// Behaviour
// - Button press sets button press flag
// - Working, enabled press flag raises control interrupt
// - Sleeping, enabled press flag raises wake event
// - Button press always wakes, drives power on
// - Flags hardware-set, write-one clears (wake flag only while on), reset clears
// - Long held button swaps press for override flag
// - Override releases power-on output, soft off
// - Second alarm sets clock alarm flag
// - Enabled clock alarm flag raises control interrupt
// - Enabled resume while suspended sets wake flag
// - Wake flag set on power-on falling edge
// - Wake flag set moves system to on
// - Enabled timer flag raises control interrupt
// - Disabled timer flag raises no interrupt
// - Enabled global flag raises control interrupt
// - Reserved status and enable bits read zero
// - Enable byte at offset two, resets zero
// - Control interrupt gated by global interrupt enable
// - Timer bit 23 toggle sets timer flag
`timescale 1ns/1ps

module apm_event_status_enable #(
  parameter int unsigned OVERRIDE_CYCLES = apm_pkg::OVERRIDE_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] pm_block_base_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  input  wire logic        button_in_i,
  input  wire logic        clock_alarm2_i,
  input  wire logic        resume_event_i,
  input  wire logic        sleep_request_i,
  input  wire logic        timer_bit23_i,
  input  wire logic        global_release_i,
  input  wire logic        button_press_enable_i,
  input  wire logic        clock_alarm_enable_i,
  input  wire logic        button_override_enable_i,
  input  wire logic        control_interrupt_enable_i,
  output logic             control_interrupt_o,
  output logic             wake_event_o,
  output logic             power_on_output_n_o,
  output logic             power_on_output_n_oe_o,
  output logic             system_sleeping_o
);

  // ==========================================================
  // Button pin synchroniser and filtered level
  logic       btn_s1;
  logic       btn_s2;
  logic       btn_s3;
  logic       btn_level;
  wire        btn_agree   = (btn_s2 == btn_s3);
  wire        next_level  = btn_agree ? btn_s3 : btn_level;
  wire        btn_rise    = next_level && !btn_level;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      btn_s1    <= 1'b0;
      btn_s2    <= 1'b0;
      btn_s3    <= 1'b0;
      btn_level <= 1'b0;
    end
    else
    begin
      btn_s1    <= button_in_i;
      btn_s2    <= btn_s1;
      btn_s3    <= btn_s2;
      btn_level <= next_level;
    end
  end

  // ==========================================================
  // Override hold counter
  // Counts system clocks, so the threshold is only as exact as clock_i.
  logic [apm_pkg::HOLD_WIDTH-1:0] hold_count;
  logic                           hold_fired;
  wire  hold_over  = (hold_count >= apm_pkg::HOLD_WIDTH'(OVERRIDE_CYCLES));
  wire  ovr_fire   = button_override_enable_i && btn_level && hold_over && !hold_fired;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_count <= '0;
      hold_fired <= 1'b0;
    end
    else if (!btn_level)
    begin
      hold_count <= '0;
      hold_fired <= 1'b0;
    end
    else
    begin
      if (!hold_over)
        hold_count <= hold_count + 1'b1;
      if (ovr_fire)
        hold_fired <= 1'b1;
    end
  end

  // ==========================================================
  // Power state
  apm_pkg::apm_state_t state;
  apm_pkg::apm_state_t next_state;
  logic                timer_last;
  logic                press_flag;
  logic                alarm_flag;
  logic                ovr_flag;
  logic                wake_flag;
  logic                timer_flag;
  logic                global_flag;
  logic [7:0]          enable_low;

  wire  is_on      = (state == apm_pkg::APM_ON);
  wire  is_off     = (state == apm_pkg::APM_OFF);
  wire  press_en   = button_press_enable_i && press_flag;
  wire  wake_cause = btn_rise || resume_event_i || press_en;
  wire  power_up   = is_off && wake_cause && !ovr_fire;
  wire  timer_tgl  = (timer_bit23_i != timer_last);

  always_comb
  begin
    next_state = state;
    case (state)
      apm_pkg::APM_ON:
        if (ovr_fire || sleep_request_i)
          next_state = apm_pkg::APM_OFF;
      apm_pkg::APM_OFF:
        if (power_up)
          next_state = apm_pkg::APM_ON;
      default:
        next_state = apm_pkg::APM_ON;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state <= apm_pkg::APM_ON;
    else
      state <= next_state;
  end

  // ==========================================================
  // Register decode
  wire [15:0] rel_addr   = io_addr_i - pm_block_base_i;
  wire        hit_stsl   = (rel_addr == apm_pkg::OFS_STATUS_LOW);
  wire        hit_stsh   = (rel_addr == apm_pkg::OFS_STATUS_HIGH);
  wire        hit_enl    = (rel_addr == apm_pkg::OFS_ENABLE_LOW);
  wire        wr_stsl    = io_wr_i && hit_stsl;
  wire        wr_stsh    = io_wr_i && hit_stsh;
  wire        wr_enl     = io_wr_i && hit_enl;

  // Write-one clears; a set in the same cycle wins
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  wire clr_press = wr_stsh && io_wdata_i[apm_pkg::BIT_BUTTON_PRESS];
  wire clr_alarm = wr_stsh && io_wdata_i[apm_pkg::BIT_CLOCK_ALARM];
  wire clr_ovr   = wr_stsh && io_wdata_i[apm_pkg::BIT_BUTTON_OVERRIDE];
  wire clr_wake  = wr_stsh && io_wdata_i[apm_pkg::BIT_WAKE] && is_on;
  wire clr_timer = wr_stsl && io_wdata_i[apm_pkg::BIT_TIMER_EVENT];
  wire clr_glob  = wr_stsl && io_wdata_i[apm_pkg::BIT_GLOBAL_EVENT];

  // Override both clears the press flag and beats a press in its cycle
  wire next_press = ovr_fire ? 1'b0 : sticky(press_flag, btn_rise, clr_press);

  wire [7:0] status_low  = {2'b00, global_flag, 4'b0000, timer_flag};
  wire [7:0] status_high = {wake_flag, 3'b000, ovr_flag, alarm_flag, 1'b0, press_flag};
  wire [7:0] read_mux    = hit_stsl ? status_low  :
                           hit_stsh ? status_high :
                           hit_enl  ? enable_low  : 8'h00;

  // ==========================================================
  // Status and enable registers
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      press_flag  <= 1'b0;
      alarm_flag  <= 1'b0;
      ovr_flag    <= 1'b0;
      wake_flag   <= 1'b0;
      timer_flag  <= 1'b0;
      global_flag <= 1'b0;
      timer_last  <= 1'b0;
      enable_low  <= apm_pkg::ENABLE_LOW_RESET;
    end
    else
    begin
      press_flag  <= next_press;
      alarm_flag  <= sticky(alarm_flag, clock_alarm2_i, clr_alarm);
      ovr_flag    <= sticky(ovr_flag, ovr_fire, clr_ovr);
      wake_flag   <= sticky(wake_flag, power_up, clr_wake);
      timer_flag  <= sticky(timer_flag, timer_tgl, clr_timer);
      global_flag <= sticky(global_flag, global_release_i, clr_glob);
      timer_last  <= timer_bit23_i;
      if (wr_enl)
        enable_low <= io_wdata_i & apm_pkg::ENABLE_LOW_MASK;
    end
  end

  // ==========================================================
  // Interrupt and wake outputs
  wire timer_en  = enable_low[apm_pkg::BIT_TIMER_EVENT];
  wire global_en = enable_low[apm_pkg::BIT_GLOBAL_EVENT];
  wire sci_any   = (is_on && press_en)
                || (clock_alarm_enable_i && alarm_flag)
                || (timer_en && timer_flag)
                || (global_en && global_flag);
  wire next_sci  = control_interrupt_enable_i && sci_any;
  wire next_wake = is_off && press_en;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      control_interrupt_o    <= 1'b0;
      wake_event_o           <= 1'b0;
      power_on_output_n_o    <= 1'b0;
      power_on_output_n_oe_o <= 1'b1;
      system_sleeping_o      <= 1'b0;
      io_rdata_o             <= 8'h00;
    end
    else
    begin
      control_interrupt_o    <= next_sci;
      wake_event_o           <= next_wake;
      power_on_output_n_o    <= 1'b0;
      power_on_output_n_oe_o <= (next_state == apm_pkg::APM_ON);
      system_sleeping_o      <= (next_state == apm_pkg::APM_OFF);
      if (io_rd_i)
        io_rdata_o <= read_mux;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_press_flag_set: assert property (
    (btn_rise && !ovr_fire) |=> press_flag)
    else $error("button press did not set press flag");

  a_override_swap: assert property (
    ovr_fire |=> (ovr_flag && !press_flag && !power_on_output_n_oe_o))
    else $error("override did not swap flags and release power");

  a_alarm_w1c: assert property (
    (wr_stsh && io_wdata_i[2] && !clock_alarm2_i) |=> !alarm_flag)
    else $error("alarm flag not cleared by write one");

  a_sci_gated: assert property (
    !control_interrupt_enable_i |=> !control_interrupt_o)
    else $error("interrupt raised while globally disabled");

  a_timer_sci: assert property (
    (timer_bit23_i != timer_last && timer_en && control_interrupt_enable_i
      && !wr_stsl && !wr_enl) |=> timer_flag ##1 control_interrupt_o)
    else $error("timer toggle did not raise interrupt");

  a_wake_on_power: assert property (
    (is_off && power_up) |=> (wake_flag && power_on_output_n_oe_o && is_on))
    else $error("power-up did not set wake flag");

  a_button_wakes: assert property (
    (is_off && btn_rise && !ovr_fire) |=> is_on)
    else $error("button press did not wake system");

  a_sleep_wake_evt: assert property (
    (is_off && button_press_enable_i && press_flag) |=> wake_event_o)
    else $error("sleeping press flag gave no wake event");

  a_enable_resv: assert property (
    (io_rd_i && hit_enl) |=> (io_rdata_o[4:1] == 4'h0))
    else $error("reserved enable bits read nonzero");

  a_global_sci: assert property (
    (global_en && global_flag && control_interrupt_enable_i) |=> control_interrupt_o)
    else $error("enabled global flag gave no interrupt");

  a_alarm_sci: assert property (
    (clock_alarm_enable_i && alarm_flag && control_interrupt_enable_i)
      |=> control_interrupt_o)
    else $error("enabled alarm flag gave no interrupt");

  a_press_sci: assert property (
    (is_on && button_press_enable_i && press_flag && control_interrupt_enable_i)
      |=> control_interrupt_o)
    else $error("working enabled press flag gave no interrupt");

  a_quiet_no_sci: assert property (
    (!timer_en && !global_en && !clock_alarm_enable_i && !button_press_enable_i)
      |=> !control_interrupt_o)
    else $error("interrupt raised with every source disabled");

  a_wake_clr_off: assert property (
    (wr_stsh && io_wdata_i[7] && is_off && wake_flag) |=> wake_flag)
    else $error("wake flag cleared while powered off");

  a_enable_write: assert property (
    wr_enl |=> (enable_low == ($past(io_wdata_i) & apm_pkg::ENABLE_LOW_MASK)))
    else $error("enable byte write not stored");

  a_status_resv: assert property (
    (io_rd_i && hit_stsh) |=> (io_rdata_o[6:4] == 3'h0))
    else $error("reserved status bits read nonzero");

  a_hold_restart: assert property (
    !btn_level |=> (hold_count == '0))
    else $error("hold count kept after release");

  a_alarm_set: assert property (
    clock_alarm2_i |=> alarm_flag)
    else $error("alarm did not set alarm flag");

  a_press_w1c: assert property (
    (wr_stsh && io_wdata_i[0] && !btn_rise) |=> !press_flag)
    else $error("press flag not cleared by write one");

  a_timer_set: assert property (
    timer_tgl |=> timer_flag)
    else $error("timer toggle did not set timer flag");

  a_global_set: assert property (
    global_release_i |=> global_flag)
    else $error("global release did not set global flag");

  a_sleep_release: assert property (
    (is_on && sleep_request_i) |=> (!power_on_output_n_oe_o && system_sleeping_o))
    else $error("sleep request did not release power pin");

  a_wake_evt_on: assert property (
    is_on |=> !wake_event_o)
    else $error("wake event raised while working");

  a_resume_wake: assert property (
    (is_off && resume_event_i && !ovr_fire) |=> (wake_flag && is_on))
    else $error("resume while off did not set wake flag");

  a_pin_drive_low: assert property (
    power_on_output_n_oe_o |-> !power_on_output_n_o)
    else $error("driven power pin not low");

endmodule // apm_event_status_enable

// ==== apm_pkg.sv ====
// Constants for the power management event status and enable block.
// Assumes byte-wide system I/O accesses relative to the block base address.
package apm_pkg;

  // ==========================================================
  // Register offsets from the block base
  localparam logic [15:0] OFS_STATUS_LOW     = 16'h0000;
  localparam logic [15:0] OFS_STATUS_HIGH    = 16'h0001;
  localparam logic [15:0] OFS_ENABLE_LOW     = 16'h0002;

  // ==========================================================
  // Field positions
  localparam int unsigned BIT_TIMER_EVENT    = 0;
  localparam int unsigned BIT_GLOBAL_EVENT   = 5;
  localparam int unsigned BIT_BUTTON_PRESS   = 0;
  localparam int unsigned BIT_CLOCK_ALARM    = 2;
  localparam int unsigned BIT_BUTTON_OVERRIDE = 3;
  localparam int unsigned BIT_WAKE           = 7;

  // Only implemented bits are stored, the rest read as zero
  localparam logic [7:0] ENABLE_LOW_MASK     = 8'h21;
  localparam logic [7:0] STATUS_LOW_MASK     = 8'h21;
  localparam logic [7:0] STATUS_HIGH_MASK    = 8'h8d;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] ENABLE_LOW_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET        = 8'h00;

  // ==========================================================
  // Timing
  localparam longint unsigned CLOCK_HZ       = 64'd10_000_000;
  localparam longint unsigned OVERRIDE_MS    = 64'd4000;
  localparam int unsigned OVERRIDE_CYCLES    =
    int'((OVERRIDE_MS * CLOCK_HZ) / 64'd1000);
  localparam int unsigned HOLD_WIDTH         = 27;

  // ==========================================================
  // Power state
  typedef enum logic [1:0] {
    APM_ON  = 2'b01,
    APM_OFF = 2'b10
  } apm_state_t;

endpackage

// ==== apm_host_model.sv ====
// Far-side model of the open-drain power-on pin and its pull-up.
// Assumes the block pulls the pin low only while its enable is high.
`timescale 1ns/1ps

module apm_host_model (
  input  wire logic drive_n_i,
  input  wire logic drive_oe_i,
  output logic      pin_level_o
);
  // A released pin is pulled up, never left at the last driven value
  assign pin_level_o = drive_oe_i ? drive_n_i : 1'b1;
endmodule // apm_host_model

// ==== apm_event_status_enable_tb_top.sv ====
// Self-checking bench for the power management event block.
// Assumes byte I/O accesses and a 20-cycle override threshold.
`timescale 1ns/1ps

module apm_event_status_enable_tb_top;
  logic        clk;
  logic        rst;
  logic [15:0] base;
  logic [15:0] addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        btn, alarm, resume, sleep, tmr, glob;
  logic        press_en, alarm_en, ovr_en, cie;
  logic        sci, wake, drv_n, oe, sleeping, pin;
  int          fail_count;
  int          cmp_count;

  apm_event_status_enable #(
    .OVERRIDE_CYCLES(20)
  ) u_dut (
    .clock_i(clk), .sys_rst_i(rst), .pm_block_base_i(base), .io_addr_i(addr),
    .io_rd_i(io_rd), .io_wr_i(io_wr), .io_wdata_i(wdata), .io_rdata_o(rdata),
    .button_in_i(btn), .clock_alarm2_i(alarm), .resume_event_i(resume),
    .sleep_request_i(sleep), .timer_bit23_i(tmr), .global_release_i(glob),
    .button_press_enable_i(press_en), .clock_alarm_enable_i(alarm_en),
    .button_override_enable_i(ovr_en), .control_interrupt_enable_i(cie),
    .control_interrupt_o(sci), .wake_event_o(wake), .power_on_output_n_o(drv_n),
    .power_on_output_n_oe_o(oe), .system_sleeping_o(sleeping)
  );

  apm_host_model u_host (
    .drive_n_i(drv_n), .drive_oe_i(oe), .pin_level_o(pin)
  );

  // ==========================================================
  // Access and compare tasks
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    @(posedge clk);
    addr  <= base + ofs;
    wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  // Read data lands at the sampling edge and holds, so look just after the edge that follows it
  task automatic rd(input logic [15:0] ofs, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= base + ofs;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    tick(1);
    check(what, rdata, exp);
  endtask

  task automatic wait_oe(input logic exp);
    int i;
    i = 0;
    while (oe !== exp && i < 100)
    begin
      tick(1);
      i++;
    end
    check("power enable", {7'h0, oe}, {7'h0, exp});
    if (i == 100)
      results();
  endtask

  // ==========================================================
  // Clock, reset and test sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {io_rd, io_wr, btn, alarm, resume, sleep, tmr, glob} = '0;
    {press_en, alarm_en, ovr_en, cie} = '0;
    base = 16'h0400;
    addr = 16'h0000;
    wdata = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(apm_pkg::OFS_ENABLE_LOW, 8'h00, "enable reset");
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h00, "status reset");
    check("pin powered", {7'h0, pin}, 8'h00);
    wr(apm_pkg::OFS_ENABLE_LOW, 8'hff);
    rd(apm_pkg::OFS_ENABLE_LOW, 8'h21, "enable reserved");
    rd(16'h0006, 8'h00, "unmapped");
    wr(apm_pkg::OFS_STATUS_HIGH, 8'hff);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h00, "status no sw set");
    $display("test registers done");
    @(posedge clk);
    tmr <= 1'b1;
    rd(apm_pkg::OFS_STATUS_LOW, 8'h01, "timer flag");
    check("sci gated", {7'h0, sci}, 8'h00);
    @(posedge clk);
    cie <= 1'b1;
    tick(3);
    check("sci timer", {7'h0, sci}, 8'h01);
    wr(apm_pkg::OFS_STATUS_LOW, 8'h01);
    tick(2);
    check("sci timer clear", {7'h0, sci}, 8'h00);
    @(posedge clk);
    tmr <= 1'b0;
    tick(3);
    check("sci timer fall", {7'h0, sci}, 8'h01);
    wr(apm_pkg::OFS_ENABLE_LOW, 8'h20);
    tick(3);
    check("sci timer off", {7'h0, sci}, 8'h00);
    wr(apm_pkg::OFS_STATUS_LOW, 8'h01);
    rd(apm_pkg::OFS_STATUS_LOW, 8'h00, "timer clear");
    @(posedge clk);
    glob <= 1'b1;
    @(posedge clk);
    glob <= 1'b0;
    tick(3);
    check("sci global", {7'h0, sci}, 8'h01);
    wr(apm_pkg::OFS_STATUS_LOW, 8'h20);
    wr(apm_pkg::OFS_ENABLE_LOW, 8'h00);
    $display("test timer and global done");
    @(posedge clk);
    alarm    <= 1'b1;
    alarm_en <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h04, "alarm flag");
    check("sci alarm", {7'h0, sci}, 8'h01);
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h04);
    @(posedge clk);
    btn      <= 1'b1;
    press_en <= 1'b1;
    repeat (3) @(posedge clk);
    btn <= 1'b0;
    tick(8);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h01, "press flag");
    check("sci press", {7'h0, sci}, 8'h01);
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h01);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h00, "press clear");
    $display("test alarm and button done");
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    wait_oe(1'b0);
    check("pin released", {7'h0, pin}, 8'h01);
    check("sleeping", {7'h0, sleeping}, 8'h01);
    @(posedge clk);
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    wait_oe(1'b1);
    check("awake", {7'h0, sleeping}, 8'h00);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h80, "wake flag");
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    wait_oe(1'b0);
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h80);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h80, "wake kept off");
    @(posedge clk);
    btn <= 1'b1;
    repeat (3) @(posedge clk);
    btn <= 1'b0;
    wait_oe(1'b1);
    // Press flag still set, so sleeping turns it straight into a wake event
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    @(posedge clk);
    #1;
    check("wake event", {7'h0, wake}, 8'h01);
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h81);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h00, "wake clear");
    $display("test sleep and resume done");
    @(posedge clk);
    ovr_en <= 1'b1;
    btn    <= 1'b1;
    repeat (15) @(posedge clk);
    btn <= 1'b0;
    repeat (8) @(posedge clk);
    btn <= 1'b1;
    repeat (15) @(posedge clk);
    btn <= 1'b0;
    tick(8);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h01, "hold restart");
    check("hold powered", {7'h0, oe}, 8'h01);
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h01);
    @(posedge clk);
    ovr_en <= 1'b1;
    btn    <= 1'b1;
    tick(60);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h08, "override flag");
    wait_oe(1'b0);
    check("pin off", {7'h0, pin}, 8'h01);
    @(posedge clk);
    btn <= 1'b0;
    wr(apm_pkg::OFS_STATUS_HIGH, 8'h08);
    rd(apm_pkg::OFS_STATUS_HIGH, 8'h00, "override clear");
    $display("test override done");
    results();
  end
endmodule // apm_event_status_enable_tb_top
